//--- ads_seq_top.sv
/*
  Control and sequencing of a pipelined converter in dual or single channel mode,
  with an AXI4-Lite register slave and a level interrupt.
  Assumes codes on CODE_A and CODE_B are valid at the sample instant, and all
  inputs are synchronous to CLK.
*/
// Summary of operation
// - Dual mode bit set converts one group A and one group B channel per pulse.
// - Dual mode keeps converting the pair pulse after pulse while triggers continue.
// - Conversions start from a PWM event, a software write or the external start input.
// - Both channels of the pair are captured together on the hold pulse falling edge.
// - Hold pulse lasts one plus the acquisition field converter clocks, field bits 8 to 11.
// - Sampling begins two and a half converter clocks after the trigger.
// - First sample: A result after 4 converter clocks, B result after 5.
// - Later samples: results follow previous ones by three plus acquisition converter clocks in dual mode, two plus in single mode.
// - Result interrupt flags are set a few system clocks after the result update.
// - Dual mode bit clear converts one selected channel per hold pulse.
`default_nettype none

module ads_seq_top (
  input wire logic CLK, // System clock, 50 MHz.
  input wire logic RST_B, // Asynchronous reset, active low.
  input wire logic CE, // Clock enable; low freezes all state.
  input wire logic PWM_EVENT_SOURCE, // One-cycle start pulse from the PWM.
  input wire logic EXTERNAL_CONVERSION_START, // External start level; rising edge starts.
  input wire logic [ads_pkg::CODE_W-1:0] CODE_A, // Code of the selected group A input.
  input wire logic [ads_pkg::CODE_W-1:0] CODE_B, // Code of the selected group B input.
  output logic CONVERTER_CLOCK, // Converter clock, half of CLK.
  output logic SH_PULSE, // Sample/hold pulse, high while acquiring.
  output logic [2:0] CHAN_A, // Channel index for group A.
  output logic [2:0] CHAN_B, // Channel index for group B.
  output logic CHAN_GROUP, // Single mode group select, 1 for group B.
  output logic BUSY, // Sequencer running.
  output logic IRQ, // Level interrupt.
  input wire logic [7:0] S_AXI_AWADDR, // Write address.
  input wire logic S_AXI_AWVALID, // Write address valid.
  output logic S_AXI_AWREADY, // Write address ready.
  input wire logic [31:0] S_AXI_WDATA, // Write data.
  input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes.
  input wire logic S_AXI_WVALID, // Write data valid.
  output logic S_AXI_WREADY, // Write data ready.
  output logic [1:0] S_AXI_BRESP, // Write response.
  output logic S_AXI_BVALID, // Write response valid.
  input wire logic S_AXI_BREADY, // Write response ready.
  input wire logic [7:0] S_AXI_ARADDR, // Read address.
  input wire logic S_AXI_ARVALID, // Read address valid.
  output logic S_AXI_ARREADY, // Read address ready.
  output logic [31:0] S_AXI_RDATA, // Read data.
  output logic [1:0] S_AXI_RRESP, // Read response.
  output logic S_AXI_RVALID, // Read data valid.
  input wire logic S_AXI_RREADY // Read data ready.
);
  import ads_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Hold pulse length minus one, in system clocks.
  function automatic logic [4:0] hold_last(input logic [3:0] acq);
    hold_last = 5'((HOLD_BASE_CONV + int'(acq)) * HALF_PER_CONV - 1);
  endfunction : hold_last

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    merge_bytes = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge_bytes[8*i +: 8] = data[8*i +: 8];
      end
    end
  endfunction : merge_bytes

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [31:0] ctrl;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic [CODE_W-1:0] result_a;
  logic [CODE_W-1:0] result_b;
  logic aw_got, w_got;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_wr, next_aw_got, next_w_got, next_bvalid;
  logic wr_known, rd_known;
  logic [31:0] rd_data;
  logic rd_status;
  logic sw_start, ext_q, trig_req;
  ads_state_t state;
  logic [4:0] cnt;
  logic [3:0] acq_run;
  logic dual_run, group_run, pend;
  logic sample_now, overrun;
  logic [CODE_W-1:0] cap_a;
  logic a_out_v, b_out_v;
  logic [CODE_W-1:0] a_out_d, b_out_d;
  logic res_a_wr, res_b_wr;
  logic [IRQ_DELAY_CYC-1:0] dly_a, dly_b;
  logic [ST_W-1:0] st_set, st_clr;
  logic [31:0] ctrl_merged, mask_merged;

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel; address and data are taken in either order.
  assign do_wr = aw_got && w_got && !S_AXI_BVALID;
  assign next_aw_got = do_wr ? 1'b0 : (aw_got || (S_AXI_AWVALID && S_AXI_AWREADY));
  assign next_w_got = do_wr ? 1'b0 : (w_got || (S_AXI_WVALID && S_AXI_WREADY));
  assign next_bvalid = do_wr || (S_AXI_BVALID && !S_AXI_BREADY);
  assign wr_known = (awaddr_q[7:2] <= ADDR_RESULT_B[7:2]) && (awaddr_q[1:0] == 2'h0);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      S_AXI_AWREADY <= !next_aw_got && !next_bvalid;
      S_AXI_WREADY <= !next_w_got && !next_bvalid;
      S_AXI_BVALID <= next_bvalid;
      if (do_wr) begin
        S_AXI_BRESP <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign ctrl_merged = merge_bytes(ctrl, wdata_q, wstrb_q);
  assign mask_merged = merge_bytes({29'h0000_0000, mask}, wdata_q, wstrb_q);

  // Writable registers; writes to read-only offsets are accepted and dropped.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl <= CTRL_RESET;
      mask <= MASK_RESET;
      sw_start <= 1'b0;
    end else if (CE) begin
      sw_start <= 1'b0;
      if (do_wr && awaddr_q == ADDR_CONVERTER_CONTROL_ONE) begin
        ctrl <= {20'h0_0000, ctrl_merged[CTRL_WRITABLE_W-1:0]};
      end
      if (do_wr && awaddr_q == ADDR_MASK) begin
        mask <= mask_merged[ST_W-1:0];
      end
      if (do_wr && awaddr_q == ADDR_START && wstrb_q[0]) begin
        sw_start <= wdata_q[START_GO_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_known = (S_AXI_ARADDR[1:0] == 2'h0);
    case (S_AXI_ARADDR)
      ADDR_CONVERTER_CONTROL_ONE: rd_data = ctrl;
      ADDR_START: rd_data = {31'h0000_0000, BUSY};
      ADDR_STATUS: rd_data = {29'h0000_0000, status};
      ADDR_MASK: rd_data = {29'h0000_0000, mask};
      ADDR_RESULT_A: rd_data = {20'h0_0000, result_a};
      ADDR_RESULT_B: rd_data = {20'h0_0000, result_b};
      default: rd_known = 1'b0;
    endcase
  end

  assign rd_status = S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == ADDR_STATUS;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RDATA <= rd_data;
        S_AXI_RRESP <= rd_known ? RESP_OKAY : RESP_SLVERR;
        S_AXI_RVALID <= 1'b1;
        S_AXI_ARREADY <= 1'b0;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end else begin
        S_AXI_ARREADY <= !S_AXI_RVALID;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trigger sources; the external start is edge detected so a held level starts once.
  assign trig_req = (PWM_EVENT_SOURCE && ctrl[CTRL_PWM_EN_BIT])
                 || (EXTERNAL_CONVERSION_START && !ext_q && ctrl[CTRL_EXT_EN_BIT])
                 || sw_start;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ext_q <= 1'b0;
    end else if (CE) begin
      ext_q <= EXTERNAL_CONVERSION_START;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Converter clock. Each system clock is one converter half period, so both converter
  // edges are available for counting.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CONVERTER_CLOCK <= 1'b0;
    end else if (CE) begin
      CONVERTER_CLOCK <= !CONVERTER_CLOCK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer. The gap after each pulse sets the sample period; a trigger seen during
  // a run is held and starts the next pulse without the lead-in delay.
  assign sample_now = (state == S_HOLD) && (cnt == 5'h00);
  assign overrun = trig_req && pend && (state != S_IDLE);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= S_IDLE;
      cnt <= 5'h00;
      acq_run <= 4'h0;
      dual_run <= 1'b0;
      group_run <= 1'b0;
      pend <= 1'b0;
      SH_PULSE <= 1'b0;
      BUSY <= 1'b0;
      CHAN_A <= 3'h0;
      CHAN_B <= 3'h0;
      CHAN_GROUP <= 1'b0;
    end else if (CE) begin
      case (state)
        S_IDLE: begin
          if (trig_req) begin
            state <= S_LEAD;
            cnt <= 5'(LEAD_CYC - 1);
            acq_run <= ctrl[CTRL_ACQ_LSB +: 4];
            dual_run <= ctrl[CTRL_DUAL_BIT];
            group_run <= !ctrl[CTRL_DUAL_BIT] && ctrl[CTRL_GROUP_BIT];
            CHAN_A <= ctrl[CTRL_CHAN_LSB +: 3];
            CHAN_B <= ctrl[CTRL_CHAN_LSB +: 3];
            CHAN_GROUP <= !ctrl[CTRL_DUAL_BIT] && ctrl[CTRL_GROUP_BIT];
            BUSY <= 1'b1;
          end
        end
        S_LEAD: begin
          pend <= pend || trig_req;
          if (cnt == 5'h00) begin
            state <= S_HOLD;
            cnt <= hold_last(acq_run);
            SH_PULSE <= 1'b1;
          end else begin
            cnt <= cnt - 5'h01;
          end
        end
        S_HOLD: begin
          pend <= pend || trig_req;
          if (cnt == 5'h00) begin
            state <= S_GAP;
            SH_PULSE <= 1'b0;
            cnt <= dual_run ? 5'(GAP_DUAL_CYC - 1) : 5'(GAP_SINGLE_CYC - 1);
          end else begin
            cnt <= cnt - 5'h01;
          end
        end
        S_GAP: begin
          if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
            pend <= pend || trig_req;
          end else if (pend || trig_req) begin
            state <= S_HOLD;
            pend <= 1'b0;
            cnt <= hold_last(acq_run);
            SH_PULSE <= 1'b1;
          end else begin
            state <= S_IDLE;
            BUSY <= 1'b0;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Capture and result pipelines. Both codes enter on the same falling edge.
  assign cap_a = group_run ? CODE_B : CODE_A;

  ads_delay_line #(.DEPTH(RES_A_CYC)) u_pipe_a (
    .clk(CLK),
    .rst_b(RST_B),
    .ce(CE),
    .in_valid(sample_now),
    .in_data(cap_a),
    .out_valid(a_out_v),
    .out_data(a_out_d)
  );

  ads_delay_line #(.DEPTH(RES_B_CYC)) u_pipe_b (
    .clk(CLK),
    .rst_b(RST_B),
    .ce(CE),
    .in_valid(sample_now && dual_run),
    .in_data(CODE_B),
    .out_valid(b_out_v),
    .out_data(b_out_d)
  );

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      result_a <= 12'h000;
      result_b <= 12'h000;
      res_a_wr <= 1'b0;
      res_b_wr <= 1'b0;
    end else if (CE) begin
      res_a_wr <= a_out_v;
      res_b_wr <= b_out_v;
      if (a_out_v) begin
        result_a <= a_out_d;
      end
      if (b_out_v) begin
        result_b <= b_out_d;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result flags lag the result update so software never sees a flag before data.
  assign st_set = {overrun, dly_b[IRQ_DELAY_CYC-1], dly_a[IRQ_DELAY_CYC-1]};
  assign st_clr = rd_status ? status : 3'h0;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dly_a <= '0;
      dly_b <= '0;
      status <= 3'h0;
      IRQ <= 1'b0;
    end else if (CE) begin
      dly_a <= {dly_a[IRQ_DELAY_CYC-2:0], a_out_v};
      dly_b <= {dly_b[IRQ_DELAY_CYC-2:0], b_out_v};
      status <= (status & ~st_clr) | st_set;
      IRQ <= |(status & mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks; they assume CE stays high.
  a_lead_delay: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == S_IDLE && trig_req && CE) |-> ##(LEAD_CYC + 1) $rose(SH_PULSE))
    else $error("Hold pulse did not start two and a half converter clocks after trigger.");

  a_hold_width: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(SH_PULSE) |-> (SH_PULSE && cnt == hold_last(acq_run)))
    else $error("Hold pulse length not loaded from the acquisition field.");

  a_first_result_a: assert property (@(posedge CLK) disable iff (!RST_B)
    $fell(SH_PULSE) |-> ##(RES_A_CYC) (res_a_wr && result_a == $past(cap_a, RES_A_CYC + 1)))
    else $error("Group A result not written four converter clocks after sampling.");

  a_first_result_b: assert property (@(posedge CLK) disable iff (!RST_B)
    ($fell(SH_PULSE) && dual_run) |-> ##(RES_B_CYC) (res_b_wr && $past(res_a_wr, 2)))
    else $error("Group B result not written five converter clocks after sampling.");

  a_single_no_b: assert property (@(posedge CLK) disable iff (!RST_B)
    ($fell(SH_PULSE) && !dual_run) |-> ##(RES_B_CYC) !res_b_wr)
    else $error("Single channel mode wrote a group B result.");

  a_pair_index: assert property (@(posedge CLK) disable iff (!RST_B)
    (BUSY && dual_run) |-> (CHAN_A == CHAN_B && !CHAN_GROUP))
    else $error("Dual mode channels differ in index.");

  a_cont_period: assert property (@(posedge CLK) disable iff (!RST_B)
    ($fell(SH_PULSE) && dual_run && pend) |-> ##(GAP_DUAL_CYC) $rose(SH_PULSE))
    else $error("Next dual sample not three plus acquisition clocks after previous.");

  a_flag_after: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(status[ST_RES_A]) |-> $past(res_a_wr, IRQ_DELAY_CYC))
    else $error("Result flag set without a result write two cycles earlier.");

  a_flag_set: assert property (@(posedge CLK) disable iff (!RST_B)
    res_b_wr |-> ##(IRQ_DELAY_CYC) status[ST_RES_B])
    else $error("Group B flag not set after result write.");

  a_conv_clock: assert property (@(posedge CLK) disable iff (!RST_B)
    (RST_B && CE) |=> (CONVERTER_CLOCK != $past(CONVERTER_CLOCK)))
    else $error("Converter clock did not toggle every system clock.");

endmodule : ads_seq_top

`default_nettype wire

//--- ads_pkg.sv
/*
  Constants for the dual-channel sample sequencer: register map, control fields,
  status bits, reset values and every sequencing delay but the hold pulse base expressed in system clocks.
  Assumes a 50 MHz system clock and a converter clock of half that rate.
*/
`default_nettype none

package ads_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Clock relationship.
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_CLK_PERIOD_NS = 40;
  // One system clock is half a converter clock, so half-period delays are exact.
  localparam int HALF_PER_CONV = CONV_CLK_PERIOD_NS / CLK_PERIOD_NS;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencing delays in converter clocks, then in system clocks.
  localparam int LEAD_TENTHS_CONV = 25;
  localparam int RES_A_FIRST_CONV = 4;
  localparam int RES_B_FIRST_CONV = 5;
  localparam int PERIOD_DUAL_EXTRA_CONV = 3;
  localparam int PERIOD_SINGLE_EXTRA_CONV = 2;
  localparam int HOLD_BASE_CONV = 1;
  localparam int LEAD_CYC = (LEAD_TENTHS_CONV * HALF_PER_CONV) / 10;
  localparam int RES_A_CYC = RES_A_FIRST_CONV * HALF_PER_CONV;
  localparam int RES_B_CYC = RES_B_FIRST_CONV * HALF_PER_CONV;
  localparam int GAP_DUAL_CYC = (PERIOD_DUAL_EXTRA_CONV - HOLD_BASE_CONV) * HALF_PER_CONV;
  localparam int GAP_SINGLE_CYC = (PERIOD_SINGLE_EXTRA_CONV - HOLD_BASE_CONV) * HALF_PER_CONV;
  localparam int IRQ_DELAY_CYC = 2;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] ADDR_CONVERTER_CONTROL_ONE = 8'h00;
  localparam logic [7:0] ADDR_START = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_RESULT_A = 8'h10;
  localparam logic [7:0] ADDR_RESULT_B = 8'h14;

  // Control register fields.
  localparam int CTRL_CHAN_LSB = 0;
  localparam int CTRL_GROUP_BIT = 3;
  localparam int CTRL_DUAL_BIT = 4;
  localparam int CTRL_PWM_EN_BIT = 5;
  localparam int CTRL_EXT_EN_BIT = 6;
  localparam int CTRL_ACQ_LSB = 8;
  localparam int CTRL_WRITABLE_W = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0060;
  localparam int START_GO_BIT = 0;

  // Status and mask bits.
  localparam int ST_RES_A = 0;
  localparam int ST_RES_B = 1;
  localparam int ST_OVERRUN = 2;
  localparam int ST_W = 3;
  localparam logic [2:0] MASK_RESET = 3'h0;

  localparam int CODE_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {S_IDLE, S_LEAD, S_HOLD, S_GAP} ads_state_t;

endpackage : ads_pkg

`default_nettype wire

//--- ads_delay_line.sv
/*
  Fixed-depth pipeline that carries a captured conversion code with a valid flag.
  Assumes the caller loads it on the sample instant and reads the last stage.
*/
`default_nettype none

module ads_delay_line #(
  parameter int DEPTH = 7
) (
  input wire logic clk, // System clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic in_valid, // Code captured this cycle.
  input wire logic [ads_pkg::CODE_W-1:0] in_data, // Captured code.
  output logic out_valid, // Last stage valid.
  output logic [ads_pkg::CODE_W-1:0] out_data // Last stage code.
);
  import ads_pkg::*;

  logic [DEPTH-1:0] vld;
  logic [CODE_W-1:0] dat [DEPTH];

  // Several samples can be in flight at once, so each stage keeps its own code.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vld <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        dat[i] <= '0;
      end
    end else if (ce) begin
      vld[0] <= in_valid;
      dat[0] <= in_data;
      for (int i = 1; i < DEPTH; i++) begin
        vld[i] <= vld[i-1];
        dat[i] <= dat[i-1];
      end
    end
  end

  assign out_valid = vld[DEPTH-1];
  assign out_data = dat[DEPTH-1];

endmodule : ads_delay_line

`default_nettype wire

//--- ads_src_model.sv
/*
  Stand-in for the analog inputs behind the sequencer.
  Assumes the sequencer's hold pulse and channel outputs; runs on the system clock.
*/
`default_nettype none

module ads_src_model import ads_pkg::*; (
  input wire logic clk, // System clock.
  input wire logic sh_pulse, // Hold pulse from the sequencer.
  input wire logic [2:0] chan_a, // Group A channel.
  input wire logic [2:0] chan_b, // Group B channel.
  output logic [CODE_W-1:0] code_a, // Group A code.
  output logic [CODE_W-1:0] code_b // Group B code.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] n = 8'h00;
  logic sh_d = 1'b0;

  // Codes carry channel, group and pulse count, so a stale or swapped capture shows.
  // They move only at a run start and one clock after a pulse opens, so they stand still until it closes.
  always @(posedge clk) begin
    sh_d <= sh_pulse;
    if (sh_pulse && !sh_d) begin
      n <= n + 8'h01;
    end
  end
  assign code_a = {chan_a, 1'b0, n};
  assign code_b = {chan_b, 1'b1, n};
endmodule : ads_src_model

`default_nettype wire

//--- ads_seq_top_bench.sv
/*
  Self-checking bench for the sequencer: register bus tasks and conversion runs.
  Assumes ads_src_model stands in for the analog inputs.
*/
`default_nettype none

module ads_seq_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ads_pkg::*;

  logic clk = 0, rst_b = 0, pwm = 0, ext = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [CODE_W-1:0] ca, cb;
  logic [31:0] rdat;
  logic [2:0] cha, chb;
  logic [1:0] br, rr;
  logic cclk, sh, grp, busy, irq, awr, wrd, bv, arr, rv;
  int n_fail = 0;
  int comparisons = 0;

  ads_seq_top i_dut (.CLK(clk), .RST_B(rst_b), .CE(1'b1), .PWM_EVENT_SOURCE(pwm),
    .EXTERNAL_CONVERSION_START(ext), .CODE_A(ca), .CODE_B(cb), .CONVERTER_CLOCK(cclk),
    .SH_PULSE(sh), .CHAN_A(cha), .CHAN_B(chb), .CHAN_GROUP(grp), .BUSY(busy), .IRQ(irq),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry));
  ads_src_model i_src (.clk(clk), .sh_pulse(sh), .chan_a(cha), .chan_b(chb), .code_a(ca), .code_b(cb));

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    bit pa, pd;
    pa = 1;
    pd = 1;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    while (pa || pd) begin
      @(posedge clk);
      if (pa && awr) begin pa = 0; awv <= 0; end
      if (pd && wrd) begin pd = 0; wv <= 0; end
    end
    do @(posedge clk); while (bv !== 1'b1);
    chk("write response", er, br);
    bry <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rdat;
    r = rr;
    rry <= 0;
  endtask : rd

  // One conversion run; kind 0 is a PWM event, 1 a software start, 2 the external pin.
  // With two set a second PWM event lands during the hold pulse.
  task automatic run(input string nm, input logic [31:0] ctl, input logic [2:0] msk, input int kind,
                     input bit two);
    int acq, n, irq_at, rise_at;
    logic [31:0] d;
    logic [1:0] r;
    logic [CODE_W-1:0] ex, eb;
    acq = int'(ctl[11:8]);
    wr(ADDR_CONVERTER_CONTROL_ONE, ctl);
    wr(ADDR_MASK, {29'h0, msk});
    if (kind == 1) wr(ADDR_START, 32'h0000_0001);
    else begin
      @(posedge clk);
      if (kind == 0) pwm <= 1;
      else ext <= 1;
    end
    n = 0;
    do begin @(posedge clk); pwm <= 0; #1; n++; end while (sh !== 1'b1 && n < 60);
    if (kind != 1) chk({nm, " lead"}, LEAD_CYC + 1, n);
    if (ctl[4]) chk({nm, " pair"}, {26'h0, ctl[2:0], ctl[2:0]}, {26'h0, cha, chb});
    else chk({nm, " group"}, ctl[3], grp);
    chk({nm, " busy"}, 1, busy);
    n = 0;
    do begin @(posedge clk); pwm <= two && n == 0; #1; n++; end while (sh === 1'b1 && n < 60);
    chk({nm, " hold width"}, 2 * (1 + acq), n);
    ex = ((ctl[4] || !ctl[3]) ? ca : cb) + CODE_W'(two);
    eb = cb + CODE_W'(two);
    irq_at = 0;
    rise_at = 0;
    for (n = 1; n <= 40; n++) begin
      @(posedge clk);
      pwm <= 0;
      #1;
      if (irq === 1'b1 && irq_at == 0) irq_at = n;
      if (sh === 1'b1 && rise_at == 0) rise_at = n;
    end
    if (two) chk({nm, " gap"}, (ctl[4] ? 6 : 4) - 2, rise_at);
    chk({nm, " irq delay"}, msk == 0 ? 0 : (msk[0] ? 11 : 13), irq_at);
    repeat (24) @(posedge clk);
    #1;
    chk({nm, " idle"}, 0, busy);
    rd(ADDR_RESULT_A, d, r);
    chk({nm, " result a"}, {20'h0, ex}, d);
    if (ctl[4]) begin
      rd(ADDR_RESULT_B, d, r);
      chk({nm, " result b"}, {20'h0, eb}, d);
    end
    rd(ADDR_STATUS, d, r);
    chk({nm, " status"}, ctl[4] ? 3 : 1, d);
    repeat (2) @(posedge clk);
    #1;
    chk({nm, " irq cleared"}, 0, irq);
    $display("test %s done", nm);
  endtask : run

  // A PWM level held three cycles starts a run, leaves one trigger pending and then overruns.
  task automatic overrun_case;
    logic [31:0] d;
    logic [1:0] r;
    wr(ADDR_CONVERTER_CONTROL_ONE, 32'h0000_0F75);
    @(posedge clk);
    pwm <= 1;
    repeat (3) @(posedge clk);
    pwm <= 0;
    repeat (120) @(posedge clk);
    rd(ADDR_STATUS, d, r);
    chk("overrun status", 32'h0000_0007, d);
    rd(ADDR_STATUS, d, r);
    chk("status read clear", 0, d);
    $display("test overrun done");
  endtask : overrun_case

  task automatic wrap_up;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (6) @(posedge clk);
    rst_b <= 1;
    rd(ADDR_CONVERTER_CONTROL_ONE, d, r);
    chk("control reset", CTRL_RESET, d);
    rd(ADDR_MASK, d, r);
    chk("mask reset", 0, d);
    rd(8'h20, d, r);
    chk("unmapped response", RESP_SLVERR, r);
    wr(8'h20, 32'h0000_0000, RESP_SLVERR);
    run("dual pwm", 32'h0000_0075, 3'h1, 0, 0);
    run("dual sw acq15", 32'h0000_0F75, 3'h2, 1, 1);
    run("single ext", 32'h0000_036A, 3'h0, 2, 1);
    overrun_case();
    wrap_up();
  end

  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
endmodule : ads_seq_top_bench

`default_nettype wire
